/* File: dpc_pkg.sv */
package dpc_pkg;

    localparam int DPC_DATA_W    = 16;
    localparam int DPC_CHANNELS  = 6;
    localparam int DPC_PER_DAC   = 3;
    localparam int DPC_HIST_W    = 15;
    localparam int DPC_ADDR_W    = 12;
    localparam int DPC_IDX_W     = 10;

    // Register indices; byte address is four times the index
    localparam logic [9:0] DPC_IDX_CTRL     = 10'h14b;
    localparam logic [9:0] DPC_IDX_TALLY0   = 10'h14c;
    localparam logic [9:0] DPC_IDX_TALLY1   = 10'h14d;
    localparam logic [9:0] DPC_IDX_CHOICE   = 10'h14e;
    localparam logic [9:0] DPC_IDX_INT_STAT = 10'h170;
    localparam logic [9:0] DPC_IDX_INT_MASK = 10'h171;

    // Control register fields
    localparam int DPC_EN_BIT     = 0;
    localparam int DPC_CLR_BIT    = 1;
    localparam int DPC_MODE_BIT   = 2;
    localparam int DPC_INV_I_BIT  = 3;
    localparam int DPC_INV_Q_BIT  = 4;
    localparam int DPC_GOOD_I_BIT = 6;
    localparam int DPC_GOOD_Q_BIT = 7;

    localparam logic [7:0] DPC_CTRL_RESET   = 8'h10;
    localparam logic [2:0] DPC_CHOICE_RESET = 3'h7;
    localparam logic [2:0] DPC_SEL_ALL      = 3'h6;
    localparam logic [7:0] DPC_COUNT_MAX    = 8'hff;
    localparam logic [1:0] DPC_INT_RESET    = 2'h0;

    // Interrupt status bits: path 0 mismatch, path 1 mismatch
    localparam int DPC_INT_W      = 2;

    // Generator taps on the history register, newest bit at index 0
    localparam int DPC_P7_TAP_A   = 6;
    localparam int DPC_P7_TAP_B   = 5;
    localparam int DPC_P15_TAP_A  = 14;
    localparam int DPC_P15_TAP_B  = 13;

    typedef struct packed {
        logic                  valid;
        logic [DPC_DATA_W-1:0] i_data;
        logic [DPC_DATA_W-1:0] q_data;
    } dpc_sample_type;

    typedef struct packed {
        logic                  miss;
        logic [DPC_HIST_W-1:0] hist;
    } dpc_check_type;

    typedef enum logic {
        DPC_BUS_IDLE = 1'b0,
        DPC_BUS_ACK  = 1'b1
    } dpc_bus_state_type;

endpackage

/* File: dpc_prbs_checker.sv */
// Implementation choice: register access over Avalon-MM.
`timescale 1ns/1ps

// Behaviour
// R1: Path 0 mismatch count readable, 8 bits; clear control zeroes every counter.
// R2: Path 1 mismatch count readable, 8 bits; checking only while enable is 1.
// R3: Three-bit readback channel selector, reset value 7.
// R4: Selector 0, 1, 2 shows converter 0 channels 0, 1, 2.
// R5: Selector 3, 4, 5 shows converter 1 channels 0, 1, 2.
// R6: Selector 6 ORs good flags and sums counts over all channels.
// R7: Sticky good flag drops on mismatch, returns to 1 only by clear.
// R8: Polynomial select 0 is x^7+x^6+1, 1 is x^15+x^14+1.
// R9: Error counters saturate at 255 instead of wrapping.
module dpc_prbs_checker
    import dpc_pkg::*;
#(
    parameter int DATA_W   = DPC_DATA_W,
    parameter int CHANNELS = DPC_CHANNELS
) (
    input  wire logic                  clk_sys_in,
    input  wire logic                  reset_n_in,
    input  wire dpc_sample_type        sample_in [CHANNELS],
    input  wire logic [DPC_ADDR_W-1:0] avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [31:0]           avs_writedata_in,
    input  wire logic [3:0]            avs_byteenable_in,
    output logic      [31:0]           avs_readdata_out,
    output logic                       avs_waitrequest_out,
    output logic                       irq_out
);

    localparam int NCHK = 2 * CHANNELS;

    dpc_bus_state_type     bus_state_reg;
    logic                  wait_reg;
    logic [31:0]           readdata_reg;
    logic [31:0]           readdata_next;
    logic                  irq_reg;
    logic [7:0]            ctrl_reg;
    logic [2:0]            choice_reg;
    logic [DPC_INT_W-1:0]  int_stat_reg;
    logic [DPC_INT_W-1:0]  int_mask_reg;
    logic [DPC_INT_W-1:0]  int_event;
    logic [DPC_HIST_W-1:0] hist_reg   [NCHK];
    logic                  primed_reg [NCHK];
    logic [7:0]            count_reg  [NCHK];
    logic                  good_reg   [NCHK];
    dpc_check_type         check_res  [NCHK];
    logic                  chk_valid  [NCHK];
    logic                  chk_miss   [NCHK];
    logic                  sel_good_i;
    logic                  sel_good_q;
    logic [7:0]            sel_count_i;
    logic [7:0]            sel_count_q;
    logic [DPC_IDX_W-1:0]  bus_index;
    logic                  bus_write_ack;
    logic                  chk_enable;
    logic                  chk_clear;
    logic                  wr_ctrl;
    logic                  wr_choice;
    logic                  wr_stat;
    logic                  wr_mask;

    // Samples arrive MSB first; the history is rebuilt from received bits so
    // the checker locks to any phase of the sequence without a seed.
    function automatic dpc_check_type check_word(
        input logic [DPC_HIST_W-1:0] hist,
        input logic [DATA_W-1:0]     word,
        input logic                  inv,
        input logic                  mode
    );
        dpc_check_type r;
        logic          b;
        logic          e;
        r.miss = 1'b0;
        r.hist = hist;
        b      = 1'b0;
        e      = 1'b0;
        for (int k = DATA_W - 1; k >= 0; k--) begin
            b = word[k] ^ inv;
            if (mode) begin // see R8
                e = r.hist[DPC_P15_TAP_A] ^ r.hist[DPC_P15_TAP_B];
            end else begin
                e = r.hist[DPC_P7_TAP_A] ^ r.hist[DPC_P7_TAP_B];
            end
            if (b != e) begin
                r.miss = 1'b1;
            end
            r.hist = {r.hist[DPC_HIST_W-2:0], b};
        end
        return r;
    endfunction

    function automatic logic [7:0] sat_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[8] ? DPC_COUNT_MAX : s[7:0];
    endfunction

    assign chk_enable          = ctrl_reg[DPC_EN_BIT];
    assign chk_clear           = ctrl_reg[DPC_CLR_BIT];
    assign bus_index           = avs_address_in[DPC_ADDR_W-1:2];
    assign bus_write_ack       = (bus_state_reg == DPC_BUS_ACK) && avs_write_in
                                 && avs_byteenable_in[0];
    assign avs_readdata_out    = readdata_reg;
    assign avs_waitrequest_out = wait_reg;
    assign irq_out             = irq_reg;

    // Checkers 0..CHANNELS-1 watch I lanes, the rest watch Q lanes
    always_comb begin
        for (int c = 0; c < CHANNELS; c++) begin
            check_res[c]          = check_word(hist_reg[c], sample_in[c].i_data,
                                               ctrl_reg[DPC_INV_I_BIT],
                                               ctrl_reg[DPC_MODE_BIT]);
            chk_valid[c]          = sample_in[c].valid;
            check_res[c+CHANNELS] = check_word(hist_reg[c+CHANNELS], sample_in[c].q_data,
                                               ctrl_reg[DPC_INV_Q_BIT],
                                               ctrl_reg[DPC_MODE_BIT]);
            chk_valid[c+CHANNELS] = sample_in[c].valid;
        end
        // Clear wins over a mismatch in the same cycle
        for (int c = 0; c < NCHK; c++) begin
            chk_miss[c] = chk_enable && !chk_clear && chk_valid[c] && primed_reg[c]
                          && check_res[c].miss; // see R2
        end
    end

    // First word after enable or clear only fills the history
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int c = 0; c < NCHK; c++) begin
                hist_reg[c]   <= '0;
                primed_reg[c] <= 1'b0;
            end
        end else begin
            for (int c = 0; c < NCHK; c++) begin
                if (chk_clear || !chk_enable) begin // see R2
                    primed_reg[c] <= 1'b0;
                end else if (chk_valid[c]) begin
                    hist_reg[c]   <= check_res[c].hist;
                    primed_reg[c] <= 1'b1;
                end
            end
        end
    end

    // Clear is a level: counters hold zero and flags hold one while it is set
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            for (int c = 0; c < NCHK; c++) begin
                count_reg[c] <= '0;
                good_reg[c]  <= 1'b0;
            end
        end else begin
            for (int c = 0; c < NCHK; c++) begin
                if (chk_clear) begin
                    count_reg[c] <= '0;   // see R1
                    good_reg[c]  <= 1'b1; // see R7
                end else if (chk_miss[c]) begin
                    good_reg[c] <= 1'b0;  // see R7
                    if (count_reg[c] != DPC_COUNT_MAX) begin // see R9
                        count_reg[c] <= count_reg[c] + 8'h01;
                    end
                end
            end
        end
    end

    // Readback selection; value 7 shows nothing
    always_comb begin
        sel_good_i  = 1'b0;
        sel_good_q  = 1'b0;
        sel_count_i = '0;
        sel_count_q = '0;
        if (choice_reg == DPC_SEL_ALL) begin
            for (int c = 0; c < CHANNELS; c++) begin
                sel_good_i  = sel_good_i | good_reg[c];                     // see R6
                sel_good_q  = sel_good_q | good_reg[c+CHANNELS];            // see R6
                sel_count_i = sat_add(sel_count_i, count_reg[c]);           // see R6
                sel_count_q = sat_add(sel_count_q, count_reg[c+CHANNELS]);  // see R6
            end
        end else if (int'(choice_reg) < DPC_PER_DAC) begin
            // Converter 0 channels
            sel_good_i  = good_reg[choice_reg];                   // see R4
            sel_good_q  = good_reg[int'(choice_reg) + CHANNELS];  // see R4
            sel_count_i = count_reg[choice_reg];                  // see R1, R4
            sel_count_q = count_reg[int'(choice_reg) + CHANNELS]; // see R2, R4
        end else if (int'(choice_reg) < CHANNELS) begin
            // Converter 1 channels; the sample channel index follows the selector
            sel_good_i  = good_reg[choice_reg];                   // see R5
            sel_good_q  = good_reg[int'(choice_reg) + CHANNELS];  // see R5
            sel_count_i = count_reg[choice_reg];                  // see R1, R5
            sel_count_q = count_reg[int'(choice_reg) + CHANNELS]; // see R2, R5
        end
    end

    // Mismatch events of each path for the interrupt
    always_comb begin
        int_event = '0;
        for (int c = 0; c < CHANNELS; c++) begin
            int_event[0] = int_event[0] | chk_miss[c];
            int_event[1] = int_event[1] | chk_miss[c+CHANNELS];
        end
    end

    always_comb begin
        readdata_next = '0;
        if (bus_index == DPC_IDX_CTRL) begin
            readdata_next[7:0]            = ctrl_reg;
            readdata_next[5]              = 1'b0;
            readdata_next[DPC_GOOD_I_BIT] = sel_good_i;
            readdata_next[DPC_GOOD_Q_BIT] = sel_good_q;
        end else if (bus_index == DPC_IDX_TALLY0) begin
            readdata_next[7:0] = sel_count_i; // see R1
        end else if (bus_index == DPC_IDX_TALLY1) begin
            readdata_next[7:0] = sel_count_q; // see R2
        end else if (bus_index == DPC_IDX_CHOICE) begin
            readdata_next[2:0] = choice_reg;  // see R3
        end else if (bus_index == DPC_IDX_INT_STAT) begin
            readdata_next[DPC_INT_W-1:0] = int_stat_reg;
        end else if (bus_index == DPC_IDX_INT_MASK) begin
            readdata_next[DPC_INT_W-1:0] = int_mask_reg;
        end
    end

    // One wait cycle per access; the data word stands while waitrequest is low
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            bus_state_reg <= DPC_BUS_IDLE;
            wait_reg      <= 1'b1;
            readdata_reg  <= '0;
        end else begin
            case (bus_state_reg)
                DPC_BUS_IDLE: begin
                    if (avs_read_in || avs_write_in) begin
                        bus_state_reg <= DPC_BUS_ACK;
                        wait_reg      <= 1'b0;
                        readdata_reg  <= avs_read_in ? readdata_next : 32'h0000_0000;
                    end
                end
                default: begin
                    bus_state_reg <= DPC_BUS_IDLE;
                    wait_reg      <= 1'b1;
                end
            endcase
        end
    end

    // One decode of the write strobe, shared by every register that software writes
    always_comb begin
        wr_ctrl   = 1'b0;
        wr_choice = 1'b0;
        wr_stat   = 1'b0;
        wr_mask   = 1'b0;
        if (bus_write_ack) begin
            if (bus_index == DPC_IDX_CTRL) begin
                wr_ctrl = 1'b1;
            end else if (bus_index == DPC_IDX_CHOICE) begin
                wr_choice = 1'b1;
            end else if (bus_index == DPC_IDX_INT_STAT) begin
                wr_stat = 1'b1;
            end else if (bus_index == DPC_IDX_INT_MASK) begin
                wr_mask = 1'b1;
            end
        end
    end

    // Good bits and bit 5 of the control word are not stored
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctrl_reg   <= DPC_CTRL_RESET;
            choice_reg <= DPC_CHOICE_RESET; // see R3
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= avs_writedata_in[7:0] & 8'h1f;
            end
            if (wr_choice) begin
                choice_reg <= avs_writedata_in[2:0]; // see R3
            end
        end
    end

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            int_stat_reg <= DPC_INT_RESET;
            int_mask_reg <= DPC_INT_RESET;
        end else begin
            if (wr_stat) begin
                int_stat_reg <= (int_stat_reg & ~avs_writedata_in[DPC_INT_W-1:0])
                                | int_event;
            end else begin
                int_stat_reg <= int_stat_reg | int_event;
            end
            if (wr_mask) begin
                int_mask_reg <= avs_writedata_in[DPC_INT_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(int_stat_reg & int_mask_reg);
        end
    end

endmodule

/* File: dpc_prbs_checker_assertions.sv */
`timescale 1ns/1ps
module dpc_prbs_checker_assertions
    import dpc_pkg::*;
(
    input wire logic                  clk_sys_in,
    input wire logic                  reset_n_in,
    input wire logic [DPC_ADDR_W-1:0] avs_address_in,
    input wire logic                  avs_read_in,
    input wire logic                  avs_write_in,
    input wire logic [31:0]           avs_writedata_in,
    input wire logic [3:0]            avs_byteenable_in,
    input wire logic [31:0]           avs_readdata_out,
    input wire logic                  avs_waitrequest_out,
    input wire logic                  irq_out
);
    logic       clr_h;
    logic       en_h;
    logic       msk_h;
    logic [2:0] sel_h;
    wire  [9:0] idx  = avs_address_in[11:2];
    wire        rack = avs_read_in && !avs_waitrequest_out;
    wire        tly  = rack && (idx == DPC_IDX_TALLY0 || idx == DPC_IDX_TALLY1);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    // Mirror of written controls, so readback is judged without the body
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            clr_h <= 1'b0;
            en_h  <= 1'b0;
            msk_h <= 1'b0;
            sel_h <= 3'h7;
        end else if (avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0]) begin
            if (idx == DPC_IDX_CTRL) begin
                clr_h <= avs_writedata_in[1];
                en_h  <= en_h | avs_writedata_in[0];
            end
            if (idx == DPC_IDX_CHOICE) begin
                sel_h <= avs_writedata_in[2:0];
            end
            if (idx == DPC_IDX_INT_MASK) begin
                msk_h <= |avs_writedata_in[1:0];
            end
        end
    end
    one_wait_a: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
        |=> !avs_waitrequest_out) else $error("access not answered");
    ack_pulse_a: assert property (!avs_waitrequest_out |=> avs_waitrequest_out)
        else $error("answer longer than one cycle");
    upper_zero_a: assert property (rack |-> avs_readdata_out[31:8] == 24'h0)
        else $error("read data above bit 7");
    choice_rsvd_a: assert property (rack && idx == DPC_IDX_CHOICE
        |-> avs_readdata_out[7:3] == 5'h0) else $error("selector reserved bits set");
    tally_clr_a: assert property (tly && clr_h |-> avs_readdata_out[7:0] == 8'h0)
        else $error("count not zero while clearing");
    tally_off_a: assert property (tly && !en_h |-> avs_readdata_out[7:0] == 8'h0)
        else $error("count moved before enable");
    sel_none_a: assert property (tly && sel_h == 3'h7 |-> avs_readdata_out[7:0] == 8'h0)
        else $error("selector 7 shows a count");
    good_clr_a: assert property (rack && idx == DPC_IDX_CTRL && clr_h && sel_h != 3'h7
        |-> avs_readdata_out[7:6] == 2'b11) else $error("good flags low while clearing");
    irq_quiet_a: assert property (!msk_h && !$past(msk_h) |-> !irq_out)
        else $error("interrupt with empty mask");
endmodule

bind dpc_prbs_checker dpc_prbs_checker_assertions dpc_prbs_checker_assertions_i (
    .clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .irq_out(irq_out));

/* File: dpc_prbs_source.sv */
`timescale 1ns/1ps
module dpc_prbs_source
    import dpc_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        reset_n_in,
    input  wire logic        mode_in,
    input  wire logic        stall_in,
    input  wire logic [11:0] err_in,
    output dpc_sample_type   smp_out [DPC_CHANNELS]
);
    logic [14:0] st_reg;
    logic [30:0] nx;
    // Sixteen generator steps per word, earliest bit into bit 15
    function automatic logic [30:0] step(input logic [14:0] s, input logic m);
        logic        b;
        logic [15:0] w;
        for (int k = 15; k >= 0; k--) begin
            b = m ? s[14] ^ s[13] : s[6] ^ s[5];
            w[k] = b;
            s = {s[13:0], b};
        end
        return {s, w};
    endfunction
    always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_reg <= 15'h7fff;
        end else if (!stall_in) begin
            st_reg <= nx[30:16];
        end
    end
    // Flipping bit 15 keeps the fault inside one word for both generators
    always_comb begin
        nx = step(st_reg, mode_in);
        for (int c = 0; c < DPC_CHANNELS; c++) begin
            smp_out[c].valid  = !stall_in;
            smp_out[c].i_data = stall_in ? ~nx[15:0] : nx[15:0] ^ {err_in[c], 15'h0};
            smp_out[c].q_data = stall_in ? nx[15:0] : ~nx[15:0] ^ {err_in[c + 6], 15'h0};
        end
    end
endmodule

/* File: dpc_prbs_checker_tb_top.sv */
`timescale 1ns/1ps
module dpc_prbs_checker_tb_top
    import dpc_pkg::*;
;
    logic           clk_sys_in;
    logic           reset_n_in = 1'b0;
    logic           mode = 1'b0, stall = 1'b1, rd = 1'b0, wr = 1'b0, wreq, irq;
    logic [11:0]    err = 12'h0, adr = 12'h0;
    logic [31:0]    wd = 32'h0, rdata, rs = 32'd43938;
    logic [3:0]     be = 4'h1;
    logic [41:0]    ent;
    logic [41:0]    expq [$];
    logic           gi [7], gq [7];
    int             ni [7], nq [7], n_mismatch = 0, check_count = 0;
    dpc_sample_type smp [DPC_CHANNELS];

    dpc_prbs_checker dpc_prbs_checker_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .sample_in(smp), .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wd), .avs_byteenable_in(be), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wreq), .irq_out(irq));
    dpc_prbs_source dpc_prbs_source_i (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
        .mode_in(mode), .stall_in(stall), .err_in(err), .smp_out(smp));

    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end
    function automatic logic [31:0] rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // An edge always passes first, so back-to-back calls never drive a strobe twice at once
    task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d);
        @(posedge clk_sys_in);
        adr <= {i, 2'b00};
        wd  <= {24'h0, d};
        wr  <= w;
        rd  <= !w;
        do @(posedge clk_sys_in); while (wreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rdx(input logic [9:0] i, input logic [7:0] e);
        expq.push_back({i, 24'h0, e});
        bus(1'b0, i, 8'h00);
    endtask
    task automatic irqc(input logic e);
        repeat (2) @(negedge clk_sys_in);
        chk("irq_out", {31'h0, irq}, {31'h0, e});
    endtask
    // One corrupted word per round, then a clean word or a random gap
    task automatic feed(input int n, input logic [11:0] m);
        repeat (n) begin
            @(posedge clk_sys_in);
            stall <= 1'b0;
            err   <= m;
            @(posedge clk_sys_in);
            err   <= 12'h0;
            stall <= 1'(rnd());
        end
    endtask
    always @(posedge clk_sys_in) begin
        if (rd && wreq === 1'b0) begin
            ent = expq.pop_front();
            chk($sformatf("reg_%h", ent[41:32]), rdata, ent[31:0]);
        end
    end
    initial begin
        #100us;
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        rdx(DPC_IDX_CHOICE, 8'h07);
        rdx(DPC_IDX_CTRL, 8'h10);
        rdx(DPC_IDX_TALLY0, 8'h00);
        rdx(10'h3ff, 8'h00);
        feed(4, 12'hfff);
        rdx(DPC_IDX_TALLY1, 8'h00);
        rdx(DPC_IDX_INT_STAT, 8'h00);
        for (int m = 0; m < 2; m++) begin
            mode <= m[0];
            bus(1'b1, DPC_IDX_CHOICE, 8'h06);
            bus(1'b1, DPC_IDX_CTRL, 8'h13 | 8'(m << 2));
            rdx(DPC_IDX_TALLY0, 8'h00);
            rdx(DPC_IDX_TALLY1, 8'h00);
            rdx(DPC_IDX_CTRL, 8'hd3 | 8'(m << 2));
            bus(1'b1, DPC_IDX_CTRL, 8'h11 | 8'(m << 2));
            feed(2, 12'h0);
            ni[6] = 0;
            nq[6] = 0;
            gi[6] = 1'b0;
            gq[6] = 1'b0;
            for (int c = 0; c < 6; c++) begin
                ni[c] = rnd() % 3;
                nq[c] = rnd() % 3;
                feed(ni[c], 12'h1 << c);
                feed(nq[c], 12'h40 << c);
                gi[c] = ni[c] == 0;
                gq[c] = nq[c] == 0;
                ni[6] += ni[c];
                nq[6] += nq[c];
                gi[6] |= gi[c];
                gq[6] |= gq[c];
            end
            for (int s = 0; s < 7; s++) begin
                bus(1'b1, DPC_IDX_CHOICE, 8'(s));
                rdx(DPC_IDX_TALLY0, 8'(ni[s]));
                rdx(DPC_IDX_TALLY1, 8'(nq[s]));
                rdx(DPC_IDX_CTRL, {gq[s], gi[s], 6'h11 | 6'(m << 2)});
            end
        end
        feed(300, 12'h041);
        rdx(DPC_IDX_TALLY0, 8'hff);
        bus(1'b1, DPC_IDX_CTRL, 8'h14);
        feed(4, 12'hfff);
        bus(1'b1, DPC_IDX_CHOICE, 8'h00);
        rdx(DPC_IDX_TALLY1, 8'hff);
        be <= 4'h0;
        bus(1'b1, DPC_IDX_CHOICE, 8'h05);
        be <= 4'h1;
        rdx(DPC_IDX_CHOICE, 8'h00);
        bus(1'b1, DPC_IDX_CTRL, 8'h0f);
        bus(1'b1, DPC_IDX_CTRL, 8'h0d);
        feed(2, 12'h0);
        rdx(DPC_IDX_CTRL, 8'h0d);
        bus(1'b1, DPC_IDX_CTRL, 8'h0c);
        rdx(DPC_IDX_INT_STAT, 8'h03);
        bus(1'b1, DPC_IDX_INT_MASK, 8'h01);
        irqc(1'b1);
        bus(1'b1, DPC_IDX_INT_STAT, 8'h01);
        irqc(1'b0);
        rdx(DPC_IDX_INT_STAT, 8'h02);
        bus(1'b1, DPC_IDX_INT_MASK, 8'h02);
        irqc(1'b1);
        @(posedge clk_sys_in);
        tally_and_finish();
    end
endmodule
